// file: logic/mdfs_cfg.svh
// constants for the motor driver fault supervisor
`ifndef MDFS_CFG_SVH
`define MDFS_CFG_SVH
`define MDFS_CLK_NS 8
`define MDFS_NS_PER_US 1000
`define MDFS_SLP_MIN_NS 18000
`define MDFS_SLP_MAX_NS 35000
`define MDFS_OC_DEGLITCH_NS 3000
`define MDFS_RETRY_US 4000
`define MDFS_OL_US 10000
`define MDFS_SHORT_W 16
`define MDFS_LONG_W 24
`define MDFS_ADDR_W 4
`define MDFS_IDX_CTRL 2'h0
`define MDFS_IDX_STAT 2'h1
`define MDFS_IDX_DIAG 2'h2
`define MDFS_RESP_OK 2'h0
`define MDFS_RESP_ERR 2'h2
`define MDFS_CTRL_W 4
`define MDFS_CLR_BIT 4
`define MDFS_FETS 8
`define MDFS_OUTS 4
`define MDFS_FETS_PER_BRIDGE 4
`endif

// file: logic/mdfs_pkg.sv
// types of the motor driver fault supervisor
`include "mdfs_cfg.svh"
package mdfs_pkg;
    typedef enum logic [1:0] {
        SLP_AWAKE = 2'b00,
        SLP_PULSE = 2'b01,
        SLP_DOWN = 2'b10
    } mdfs_sleep_e;
    typedef struct packed {
        logic supply_low;
        logic pump_low;
        logic [`MDFS_FETS-1:0] fet_limit;
        logic [1:0] coil_low;
        logic warn;
        logic tsd;
        logic sleep_n;
    } mdfs_pins_s;
    typedef struct packed {
        logic warn_route;
        logic ol_en;
        logic tsd_mode;
        logic oc_mode;
    } mdfs_ctrl_s;
    typedef struct packed {
        logic [1:0] ol_w;
        logic warn;
        logic tsd;
        logic temp_any;
        logic ol;
        logic oc;
        logic pump_low;
        logic lockout;
        logic summary;
    } mdfs_flags_s;
    typedef struct packed {
        logic [`MDFS_OUTS-1:0] hs;
        logic [`MDFS_OUTS-1:0] ls;
    } mdfs_diag_s;
    typedef struct packed {
        mdfs_pins_s meta;
        mdfs_pins_s sync;
        mdfs_ctrl_s ctrl;
        mdfs_flags_s flags;
        mdfs_diag_s diag;
        logic powerup;
        logic [1:0] bridge_off;
        logic tsd_hold;
        logic [`MDFS_FETS-1:0][`MDFS_SHORT_W-1:0] oc_cnt;
        logic [1:0][`MDFS_LONG_W-1:0] ol_cnt;
        logic [`MDFS_LONG_W-1:0] retry_cnt;
        mdfs_sleep_e sleep_st;
        logic [`MDFS_SHORT_W-1:0] sleep_cnt;
        logic awready;
        logic wready;
        logic aw_got;
        logic w_got;
        logic [1:0] waddr;
        logic [7:0] wbyte;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic pin_n;
        logic pin_oe;
        logic [1:0] bridge_en;
        logic pump_en;
    } mdfs_state_s;
endpackage

// file: logic/mdfs_fault_supervisor.sv
// fault supervisor: flags, bridge gating, error pin and axi4-lite status
//
// Functional notes
// RL1: error pin driven low while any reported fault exists, released otherwise.
// RL2: error pin released after power-up once supply valid and no fault.
// RL3: supply below lockout: bridges and charge pump off; resume above rising level.
// RL4: supply lockout above core reset: bus alive, summary and lockout flags set, pin low.
// RL5: supply back: pin released, summary cleared; lockout flag held until clear.
// RL6: below core reset: core in reset, flags low, pin released.
// RL7: at power-up lockout flag stays low, summary and pin set until supply good.
// RL8: pump rail low: outputs off, pin low, pump runs, summary and pump flags set.
// RL9: pump rail good: resume, pin released, summary cleared; pump flag held until clear.
// RL10: overcurrent past deglitch: disable that bridge, pin low, latch summary and flag.
// RL11: low-side flag for short to supply, high-side flag for short to ground.
// RL12: recovery select zero: bridge stays off until clear, sleep pulse or reset.
// RL13: recovery select one: resume after retry delay once fault gone.
// RL14: open winding flagged only when enabled and coil current low past detect time.
// RL15: open winding latches flag, summary, pin and per-winding a or b flag.
// RL16: open winding clears only when gone and cleared, or on reset or wake; the code clears on wake only once the coil current is back.
// RL17: thermal shutdown: bridges and pump off, pin low, latch flags; never disabled.
// RL18: thermal select zero: outputs stay off until clear, sleep pulse or reset.
// RL19: thermal select one: resume when cool; temperature flags stay until clear.
// RL20: warning sets warning and temperature flags only, clears itself when cool.
// RL21: routing bit one: warning also drives pin and summary.
// RL22: sleep-pin low pulse between 18 and 35 us clears latched faults.
// RL23: pin and summary stay asserted while any enabled source remains active.
`include "mdfs_cfg.svh"
module mdfs_fault_supervisor #(
    parameter int OC_DEGLITCH_NS = `MDFS_OC_DEGLITCH_NS,
    parameter int RETRY_CYC = `MDFS_RETRY_US * `MDFS_NS_PER_US / `MDFS_CLK_NS,
    parameter int OL_CYC = `MDFS_OL_US * `MDFS_NS_PER_US / `MDFS_CLK_NS,
    parameter int SLP_MIN_CYC = (`MDFS_SLP_MIN_NS + `MDFS_CLK_NS - 1) / `MDFS_CLK_NS,
    parameter int SLP_MAX_CYC = `MDFS_SLP_MAX_NS / `MDFS_CLK_NS
) (
    // clock and core reset
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    // comparator and pin inputs, asynchronous
    input wire logic supply_below_lockout_in,
    input wire logic pump_rail_low_in,
    input wire logic [`MDFS_FETS-1:0] fet_current_limit_in,
    input wire logic [1:0] coil_current_low_in,
    input wire logic hot_warning_in,
    input wire logic thermal_shutdown_in,
    input wire logic sleep_pin_n_in,
    // axi4-lite write
    input wire logic [`MDFS_ADDR_W-1:0] axi_awaddr_in,
    input wire logic axi_awvalid_in,
    output logic axi_awready_out,
    input wire logic [31:0] axi_wdata_in,
    input wire logic [3:0] axi_wstrb_in,
    input wire logic axi_wvalid_in,
    output logic axi_wready_out,
    output logic [1:0] axi_bresp_out,
    output logic axi_bvalid_out,
    input wire logic axi_bready_in,
    // axi4-lite read
    input wire logic [`MDFS_ADDR_W-1:0] axi_araddr_in,
    input wire logic axi_arvalid_in,
    output logic axi_arready_out,
    output logic [31:0] axi_rdata_out,
    output logic [1:0] axi_rresp_out,
    output logic axi_rvalid_out,
    input wire logic axi_rready_in,
    // open-drain error pin and power stage gating
    output logic error_pin_n_out,
    output logic error_pin_oe_out,
    output logic [1:0] bridge_enable_out,
    output logic charge_pump_enable_out
);
    localparam logic [`MDFS_SHORT_W-1:0] OC_LIM =
        `MDFS_SHORT_W'((OC_DEGLITCH_NS + `MDFS_CLK_NS - 1) / `MDFS_CLK_NS);
    localparam logic [`MDFS_SHORT_W-1:0] SLP_MIN = `MDFS_SHORT_W'(SLP_MIN_CYC);
    localparam logic [`MDFS_SHORT_W-1:0] SLP_MAX = `MDFS_SHORT_W'(SLP_MAX_CYC);
    localparam logic [`MDFS_LONG_W-1:0] RETRY_LIM = `MDFS_LONG_W'(RETRY_CYC);
    localparam logic [`MDFS_LONG_W-1:0] OL_LIM = `MDFS_LONG_W'(OL_CYC);

    mdfs_pkg::mdfs_state_s s;
    mdfs_pkg::mdfs_state_s next_s;
    mdfs_pkg::mdfs_pins_s pins_raw;
    logic clear_now;
    logic cmd_clear;
    logic sleep_clear;
    logic [`MDFS_FETS-1:0] oc_fire;
    logic [1:0] ol_fire;
    logic [1:0] oc_release;

    // raw pins gathered for the synchroniser
    assign pins_raw = {supply_below_lockout_in, pump_rail_low_in, fet_current_limit_in,
        coil_current_low_in, hot_warning_in, thermal_shutdown_in, sleep_pin_n_in};

    // next-state logic of the whole block
    always_comb begin
        next_s = s;
        cmd_clear = 1'b0;
        sleep_clear = 1'b0;
        oc_fire = '0;
        ol_fire = '0;
        oc_release = '0;
        // two-stage synchroniser, first stage feeds only the second
        next_s.meta = pins_raw;
        next_s.sync = s.meta;

        // sleep pin: a short low pulse clears, a long one puts the pump to sleep
        case (s.sleep_st)
            mdfs_pkg::SLP_AWAKE: begin
                if (!s.sync.sleep_n) begin
                    next_s.sleep_st = mdfs_pkg::SLP_PULSE;
                    next_s.sleep_cnt = '0;
                end
            end
            mdfs_pkg::SLP_PULSE: begin
                if (s.sync.sleep_n) begin
                    sleep_clear = (s.sleep_cnt >= SLP_MIN); // RL22
                    next_s.sleep_st = mdfs_pkg::SLP_AWAKE;
                end else if (s.sleep_cnt == SLP_MAX) begin
                    next_s.sleep_st = mdfs_pkg::SLP_DOWN;
                end else begin
                    next_s.sleep_cnt = s.sleep_cnt + 1'b1;
                end
            end
            mdfs_pkg::SLP_DOWN: begin
                // waking from sleep also wipes latched faults
                if (s.sync.sleep_n) begin
                    sleep_clear = 1'b1; // RL16
                    next_s.sleep_st = mdfs_pkg::SLP_AWAKE;
                end
            end
            default: begin
                next_s.sleep_st = mdfs_pkg::SLP_AWAKE;
            end
        endcase

        // axi write: address and data taken in either order
        if (axi_awvalid_in && s.awready) begin
            next_s.aw_got = 1'b1;
            next_s.waddr = axi_awaddr_in[`MDFS_ADDR_W-1:2];
        end
        if (axi_wvalid_in && s.wready) begin
            next_s.w_got = 1'b1;
            next_s.wbyte = axi_wdata_in[7:0];
            next_s.wstrb0 = axi_wstrb_in[0];
        end
        if (s.bvalid && axi_bready_in) begin
            next_s.bvalid = 1'b0;
        end
        // commit one cycle after both halves are held
        if (s.aw_got && s.w_got && !s.bvalid) begin
            next_s.aw_got = 1'b0;
            next_s.w_got = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = `MDFS_RESP_OK;
            case (s.waddr)
                `MDFS_IDX_CTRL: begin
                    if (s.wstrb0) begin
                        next_s.ctrl = s.wbyte[`MDFS_CTRL_W-1:0];
                        cmd_clear = s.wbyte[`MDFS_CLR_BIT];
                    end
                end
                `MDFS_IDX_STAT, `MDFS_IDX_DIAG: begin
                    next_s.bresp = `MDFS_RESP_OK;
                end
                default: begin
                    next_s.bresp = `MDFS_RESP_ERR;
                end
            endcase
        end
        next_s.awready = !next_s.aw_got && !next_s.bvalid;
        next_s.wready = !next_s.w_got && !next_s.bvalid;

        // axi read: data captured at the address handshake
        if (s.rvalid && axi_rready_in) begin
            next_s.rvalid = 1'b0;
        end
        if (axi_arvalid_in && s.arready) begin
            next_s.rvalid = 1'b1;
            next_s.rresp = `MDFS_RESP_OK;
            case (axi_araddr_in[`MDFS_ADDR_W-1:2])
                `MDFS_IDX_CTRL: next_s.rdata = 32'(s.ctrl);
                `MDFS_IDX_STAT: next_s.rdata = 32'(s.flags);
                `MDFS_IDX_DIAG: next_s.rdata = 32'(s.diag);
                default: begin
                    next_s.rdata = '0;
                    next_s.rresp = `MDFS_RESP_ERR;
                end
            endcase
        end
        next_s.arready = !next_s.rvalid;

        clear_now = cmd_clear || sleep_clear; // RL22

        // supply lockout; the power-up phase keeps the lockout flag low
        next_s.powerup = s.powerup && s.sync.supply_low; // RL7
        next_s.flags.lockout = (s.flags.lockout && !clear_now) ||
            (s.sync.supply_low && !s.powerup); // RL4 RL5
        // pump rail flag latches, set beats clear
        next_s.flags.pump_low = (s.flags.pump_low && !clear_now) || s.sync.pump_low; // RL8 RL9

        // per-fet deglitch of the current limit
        for (int i = 0; i < `MDFS_FETS; i++) begin
            if (!s.sync.fet_limit[i]) begin
                next_s.oc_cnt[i] = '0;
            end else if (s.oc_cnt[i] != OC_LIM) begin
                next_s.oc_cnt[i] = s.oc_cnt[i] + 1'b1;
            end
            oc_fire[i] = s.sync.fet_limit[i] && (s.oc_cnt[i] == OC_LIM); // RL10
        end
        // even fet of an output is high side, odd is low side
        for (int k = 0; k < `MDFS_OUTS; k++) begin
            next_s.diag.hs[k] = (s.diag.hs[k] && !clear_now) || oc_fire[2*k]; // RL11
            next_s.diag.ls[k] = (s.diag.ls[k] && !clear_now) || oc_fire[2*k+1]; // RL11
        end
        next_s.flags.oc = (s.flags.oc && !clear_now) || (|oc_fire); // RL10

        // retry delay restarts on every new trip
        if ((|oc_fire) || !(|s.bridge_off)) begin
            next_s.retry_cnt = '0;
        end else if (s.retry_cnt != RETRY_LIM) begin
            next_s.retry_cnt = s.retry_cnt + 1'b1;
        end
        // only the bridge that tripped is shut off
        for (int b = 0; b < 2; b++) begin
            oc_release[b] = clear_now || (s.ctrl.oc_mode && (s.retry_cnt == RETRY_LIM) &&
                !(|s.sync.fet_limit[b*`MDFS_FETS_PER_BRIDGE +: `MDFS_FETS_PER_BRIDGE])); // RL12 RL13
            next_s.bridge_off[b] = (s.bridge_off[b] && !oc_release[b]) ||
                (|oc_fire[b*`MDFS_FETS_PER_BRIDGE +: `MDFS_FETS_PER_BRIDGE]); // RL10
        end

        // open winding: needs the enable, a clear only works once the coil is back
        for (int w = 0; w < 2; w++) begin
            if (!(s.ctrl.ol_en && s.sync.coil_low[w])) begin
                next_s.ol_cnt[w] = '0;
            end else if (s.ol_cnt[w] != OL_LIM) begin
                next_s.ol_cnt[w] = s.ol_cnt[w] + 1'b1;
            end
            ol_fire[w] = s.ctrl.ol_en && s.sync.coil_low[w] && (s.ol_cnt[w] == OL_LIM); // RL14
            next_s.flags.ol_w[w] = (s.flags.ol_w[w] && !(clear_now && !s.sync.coil_low[w])) ||
                ol_fire[w]; // RL15 RL16
        end
        next_s.flags.ol = |next_s.flags.ol_w; // RL15

        // thermal shutdown has no enable; the hold decides the power stage
        next_s.tsd_hold = s.sync.tsd ||
            (s.tsd_hold && !(!s.sync.tsd && (clear_now || s.ctrl.tsd_mode))); // RL17 RL18 RL19
        next_s.flags.tsd = (s.flags.tsd && !clear_now) || s.sync.tsd; // RL17 RL19
        // warning follows the comparator, which carries the hysteresis
        next_s.flags.warn = s.sync.warn; // RL20
        next_s.flags.temp_any = next_s.flags.tsd || s.sync.warn; // RL20

        // summary is an or of the live supply, pump and routed warning inputs, the bridge and thermal holds and the open winding flags
        next_s.flags.summary = s.sync.supply_low || s.sync.pump_low || (|next_s.bridge_off) ||
            next_s.flags.ol || next_s.tsd_hold ||
            (s.sync.warn && s.ctrl.warn_route); // RL1 RL5 RL9 RL21 RL23
        next_s.pin_oe = next_s.flags.summary; // RL1 RL2
        next_s.pin_n = !next_s.flags.summary; // RL1 RL2

        // power stage gating; the pump keeps running for rail-low and overcurrent
        for (int b = 0; b < 2; b++) begin
            next_s.bridge_en[b] = !s.sync.supply_low && !s.sync.pump_low &&
                !next_s.bridge_off[b] && !next_s.tsd_hold && s.sync.sleep_n; // RL3 RL8 RL17
        end
        next_s.pump_en = !s.sync.supply_low && !next_s.tsd_hold &&
            (next_s.sleep_st != mdfs_pkg::SLP_DOWN); // RL3 RL17
    end

    // state register; reset is the core reset, pin released, flags low
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s <= '0; // RL6
            s.pin_n <= 1'b1; // RL6
            s.powerup <= 1'b1; // RL7
            s.meta.supply_low <= 1'b1;
            s.sync.supply_low <= 1'b1;
            s.meta.sleep_n <= 1'b1;
            s.sync.sleep_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from the state register
    assign axi_awready_out = s.awready;
    assign axi_wready_out = s.wready;
    assign axi_bresp_out = s.bresp;
    assign axi_bvalid_out = s.bvalid;
    assign axi_arready_out = s.arready;
    assign axi_rdata_out = s.rdata;
    assign axi_rresp_out = s.rresp;
    assign axi_rvalid_out = s.rvalid;
    assign error_pin_n_out = s.pin_n;
    assign error_pin_oe_out = s.pin_oe;
    assign bridge_enable_out = s.bridge_en;
    assign charge_pump_enable_out = s.pump_en;

    // checks on the supervisor behaviour
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_b_in);

    a_pin_tracks_summary: assert property (
        error_pin_oe_out == s.flags.summary && error_pin_n_out == !error_pin_oe_out) // RL1
        else $error("error pin does not follow summary");
    a_pin_release_good: assert property (
        (!s.sync.supply_low && !s.sync.pump_low && !(|s.bridge_off) && !s.flags.ol &&
         !s.tsd_hold && !s.sync.tsd && !(|oc_fire) && !(|ol_fire) &&
         !s.sync.warn)[*2] |=> !error_pin_oe_out) // RL2
        else $error("error pin held with no fault");
    a_lockout_gates: assert property (
        s.sync.supply_low |=> !bridge_enable_out[0] && !bridge_enable_out[1] &&
        !charge_pump_enable_out) // RL3
        else $error("power stage on during lockout");
    a_lockout_flags: assert property (
        s.sync.supply_low && !s.powerup |=> s.flags.lockout && s.flags.summary) // RL4
        else $error("lockout flags not set");
    a_lockout_held: assert property (
        s.flags.lockout && !clear_now |=> s.flags.lockout) // RL5
        else $error("lockout flag dropped without clear");
    a_powerup_quiet: assert property (
        s.powerup && s.sync.supply_low |=> !s.flags.lockout && error_pin_oe_out) // RL7
        else $error("power-up lockout flag or pin wrong");
    a_pump_low_act: assert property (
        s.sync.pump_low |=> s.flags.pump_low && error_pin_oe_out &&
        bridge_enable_out == 2'b00) // RL8
        else $error("pump rail low not handled");
    a_oc_one_bridge: assert property (
        oc_fire[0] && !(|s.sync.fet_limit[7:4]) && !(|s.bridge_off) && !s.tsd_hold &&
        !s.sync.supply_low |=> s.bridge_off == 2'b01 && s.flags.oc &&
        !bridge_enable_out[0] && charge_pump_enable_out == (s.sleep_st != mdfs_pkg::SLP_DOWN)) // RL10
        else $error("overcurrent did not shut only its bridge");
    a_oc_side_flags: assert property (
        oc_fire[0] && oc_fire[1] |=> s.diag.hs[0] && s.diag.ls[0]) // RL11
        else $error("per-output overcurrent flags missing");
    a_oc_latched: assert property (
        s.bridge_off[0] && !s.ctrl.oc_mode && !clear_now |=> s.bridge_off[0]) // RL12
        else $error("latched overcurrent released itself");
    a_oc_retry: assert property (
        s.bridge_off[1] && s.ctrl.oc_mode && s.retry_cnt == RETRY_LIM &&
        !(|s.sync.fet_limit[7:4]) |=> !s.bridge_off[1]) // RL13
        else $error("retry did not release bridge");
    a_ol_needs_en: assert property (
        !s.ctrl.ol_en && !s.flags.ol |=> !s.flags.ol) // RL14
        else $error("open winding flagged while disabled");
    a_ol_latch: assert property (
        ol_fire[0] |=> s.flags.ol_w[0] && s.flags.ol && error_pin_oe_out) // RL15
        else $error("open winding not latched");
    a_ol_stays: assert property (
        s.flags.ol_w[0] && s.sync.coil_low[0] |=> s.flags.ol_w[0]) // RL16
        else $error("open winding cleared while present");
    a_tsd_act: assert property (
        s.sync.tsd |=> s.tsd_hold && s.flags.tsd && s.flags.temp_any &&
        !charge_pump_enable_out && bridge_enable_out == 2'b00 && error_pin_oe_out) // RL17
        else $error("thermal shutdown not handled");
    a_tsd_auto: assert property (
        s.tsd_hold && s.ctrl.tsd_mode && !s.sync.tsd && s.flags.tsd && !clear_now
        |=> !s.tsd_hold && s.flags.tsd) // RL19
        else $error("thermal auto recovery wrong");
    a_warn_flags: assert property (
        s.sync.warn |=> s.flags.warn && s.flags.temp_any) // RL20
        else $error("warning flags not set");
    a_warn_route: assert property (
        s.sync.warn && s.ctrl.warn_route |=> s.flags.summary && error_pin_oe_out) // RL21
        else $error("routed warning missing on pin");
    a_sleep_clear: assert property (
        s.sleep_st == mdfs_pkg::SLP_PULSE && s.sync.sleep_n && s.sleep_cnt >= SLP_MIN &&
        !s.sync.pump_low |=> !s.flags.pump_low) // RL22
        else $error("sleep pulse did not clear");

    c_oc_trip: cover property (oc_fire[0] ##1 s.bridge_off[0]);
    c_ol_trip: cover property (ol_fire[0]);
    c_sleep_pulse: cover property (sleep_clear && s.sleep_st == mdfs_pkg::SLP_PULSE);
    c_ctrl_write: cover property (cmd_clear ##1 axi_bvalid_out);
endmodule // mdfs_fault_supervisor

// file: tb/mdfs_host_model.sv
// host side model: pull-up on the error line and sleep pin driver
module mdfs_host_model (
    // clock and open-drain error pin
    input wire logic clk_in,
    input wire logic error_pin_oe_in,
    // host view of the line and the sleep pin
    output wire logic error_line_out,
    output logic sleep_pin_n_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // pull-up wins unless the device sinks the line
    assign error_line_out = error_pin_oe_in ? 1'b0 : 1'b1;
    initial sleep_pin_n_out = 1'b1;
    // short low pulse clears latches without sleeping
    task automatic pulse(input int n);
        @(posedge clk_in) sleep_pin_n_out <= 1'b0;
        repeat (n) @(posedge clk_in);
        sleep_pin_n_out <= 1'b1;
    endtask
endmodule // mdfs_host_model

// file: tb/tb_motor_driver_fault_supervisor.sv
// self-checking bench for the motor driver fault supervisor
module tb_motor_driver_fault_supervisor;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_b = 0, sup = 0, pmp = 0, warn = 0, tsd = 0;
    logic [7:0] fet = 0;
    logic [1:0] coil = 0;
    logic [3:0] awaddr = 0, araddr = 0;
    logic [3:0] wstrb = 4'hf;
    logic awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
    logic [31:0] wdata = 0, rdata, d;
    logic awready, wready, bvalid, arready, rvalid, pin_n, oe, pump_on, sleep_n, line;
    logic [1:0] bresp, rresp, r, bridge;
    int err_total = 0, num_checks = 0;
    // short counts keep the run brief
    mdfs_fault_supervisor #(.OC_DEGLITCH_NS(80), .RETRY_CYC(50), .OL_CYC(40),
        .SLP_MIN_CYC(20), .SLP_MAX_CYC(40)) dut (.core_clk_in(clk), .rst_b_in(rst_b),
        .supply_below_lockout_in(sup), .pump_rail_low_in(pmp), .fet_current_limit_in(fet),
        .coil_current_low_in(coil), .hot_warning_in(warn), .thermal_shutdown_in(tsd),
        .sleep_pin_n_in(sleep_n), .axi_awaddr_in(awaddr), .axi_awvalid_in(awv),
        .axi_awready_out(awready), .axi_wdata_in(wdata), .axi_wstrb_in(wstrb),
        .axi_wvalid_in(wv), .axi_wready_out(wready), .axi_bresp_out(bresp),
        .axi_bvalid_out(bvalid), .axi_bready_in(bready), .axi_araddr_in(araddr),
        .axi_arvalid_in(arv), .axi_arready_out(arready), .axi_rdata_out(rdata),
        .axi_rresp_out(rresp), .axi_rvalid_out(rvalid), .axi_rready_in(rready),
        .error_pin_n_out(pin_n), .error_pin_oe_out(oe), .bridge_enable_out(bridge),
        .charge_pump_enable_out(pump_on));
    mdfs_host_model host (.clk_in(clk), .error_pin_oe_in(oe), .error_line_out(line),
        .sleep_pin_n_out(sleep_n));
    // 125 mhz clock
    initial forever #4 clk = ~clk;
    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // hang guard, far beyond the few hundred cycles needed
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        final_report;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // wait n edges; outputs are read as they stood at the last edge
    task automatic w(input int n);
        repeat (n) @(posedge clk);
    endtask
    // pins as {pin value, line, bridge b, bridge a, pump}; pin value equals line
    task automatic pins(input logic [3:0] e);
        chk({27'h0, pin_n, line, bridge, pump_on}, {27'h0, e[3], e});
    endtask
    // write: both channels offered together, bready held until bvalid
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        awaddr <= a; wdata <= v; awv <= 1; wv <= 1; bready <= 1;
        fork
            begin do @(posedge clk); while (!awready); awv <= 0; end
            begin do @(posedge clk); while (!wready); wv <= 0; end
        join
        while (!bvalid) @(posedge clk);
        bready <= 0;
        r = bresp;
        w(3);
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        araddr <= a; arv <= 1; rready <= 1;
        do @(posedge clk); while (!arready);
        arv <= 0;
        do @(posedge clk); while (!rvalid);
        d = rdata; r = rresp; rready <= 0;
    endtask
    task automatic stat(input logic [31:0] e);
        rd(4'h4);
        chk(d, e);
    endtask
    task automatic t_power;
        w(4); pins(4'b1000);
        @(posedge clk) rst_b <= 1;
        w(2); chk({31'h0, line}, 32'h0);
        w(5); pins(4'b1111); stat(32'h0);
        rd(4'h0); chk(d, 32'h0);
        rd(4'hc); chk({d[29:0], r}, 32'h2);
        wstrb <= 4'h0; wr(4'h0, 32'h1); rd(4'h0); chk(d, 32'h0);
        wstrb <= 4'hf; wr(4'hc, 32'h1); chk({30'h0, r}, 32'h2);
    endtask
    task automatic t_supply;
        @(posedge clk) sup <= 1;
        w(5); pins(4'b0000); stat(32'h3);
        @(posedge clk) sup <= 0;
        w(5); pins(4'b1111); stat(32'h2);
        wr(4'h0, 32'h10); chk({30'h0, r}, 32'h0); stat(32'h0);
    endtask
    task automatic t_pump;
        @(posedge clk) pmp <= 1;
        w(5); pins(4'b0001); stat(32'h5);
        @(posedge clk) pmp <= 0;
        w(5); pins(4'b1111); stat(32'h4);
        host.pulse(25); w(5); stat(32'h0);
    endtask
    task automatic t_oc;
        @(posedge clk) fet <= 8'h03;
        w(4); fet <= 8'h00; w(5); pins(4'b1111);
        fet <= 8'h03; w(20); pins(4'b0101); stat(32'h9);
        rd(4'h8); chk(d, 32'h11);
        fet <= 8'h00; w(10); pins(4'b0101);
        wr(4'h0, 32'h11); pins(4'b1111); stat(32'h0);
        fet <= 8'h10; w(20); pins(4'b0011); rd(4'h8); chk(d, 32'h40);
        fet <= 8'h00; w(70); pins(4'b1111); stat(32'h8);
        wr(4'h0, 32'h10); stat(32'h0);
    endtask
    task automatic t_thermal;
        @(posedge clk) tsd <= 1;
        w(5); pins(4'b0000); stat(32'h61);
        tsd <= 0; w(5); chk({29'h0, line, bridge}, 32'h0);
        wr(4'h0, 32'h12); pins(4'b1111); stat(32'h0);
        tsd <= 1; w(5); tsd <= 0; w(5); pins(4'b1111); stat(32'h60);
        wr(4'h0, 32'h10);
    endtask
    task automatic t_warn;
        @(posedge clk) warn <= 1;
        w(5); pins(4'b1111); stat(32'ha0);
        wr(4'h0, 32'h8); pins(4'b0111); stat(32'ha1);
        warn <= 0; w(5); pins(4'b1111); stat(32'h0);
    endtask
    task automatic t_open;
        wr(4'h0, 32'h0);
        coil <= 2'b01; w(60); stat(32'h0);
        wr(4'h0, 32'h4); w(60); pins(4'b0111); stat(32'h111);
        wr(4'h0, 32'h14); stat(32'h111);
        coil <= 2'b00; wr(4'h0, 32'h14); pins(4'b1111); stat(32'h0);
    endtask
    // reset held for 9 cycles, then each scenario in turn
    initial begin
        repeat (4) @(posedge clk);
        t_power; t_supply; t_pump; t_oc; t_thermal; t_warn; t_open;
        final_report;
    end
endmodule // tb_motor_driver_fault_supervisor
